/* File: spx_codec_model.sv */
// Far-end codec model: bit clock, receive frames, transmit capture
`timescale 1ns/10ps
module spx_codec_model (
    input  wire logic        run,
    input  wire logic        rx_go,
    input  wire logic [15:0] rx_word,
    input  wire logic [4:0]  rx_bits,
    input  wire logic        tx_serial_out,
    input  wire logic        tx_serial_oe,
    output wire logic        tx_bit_clock,
    output wire logic        rx_bit_clock,
    output logic             rx_frame_sync,
    output logic             rx_serial_in,
    output logic [15:0]      tx_cap
);
    logic        ck = 1'b0;   // Shared bit clock
    logic        seen = 1'b0; // Last request toggle served
    logic [4:0]  cnt = 5'h0;  // Bits left to send
    logic [15:0] sh = 16'h0;  // Outgoing word
    initial begin
        rx_frame_sync = 1'b0;
        rx_serial_in = 1'b0;
        tx_cap = 16'h0;
    end
    // Clock stands still, held low, while run is low
    always #62.5 ck = run ? ~ck : 1'b0;
    assign tx_bit_clock = ck;
    assign rx_bit_clock = ck;
    // Frame one period ahead, then data MSB first on rising edges
    always @(posedge ck) begin
        rx_frame_sync <= 1'b0;
        if (cnt != 5'h0) begin
            rx_serial_in <= sh[15];
            sh <= sh << 1;
            cnt <= cnt - 5'h1;
        end else if (rx_go != seen) begin
            seen <= rx_go;
            rx_frame_sync <= 1'b1;
            sh <= rx_word << (5'h10 - rx_bits);
            cnt <= rx_bits;
        end else begin
            rx_serial_in <= ~rx_serial_in; // Idle line keeps moving
        end
    end
    // Transmit bits taken on falling edges while driven
    always @(negedge ck) if (tx_serial_oe) tx_cap <= {tx_cap[14:0], tx_serial_out};
endmodule // spx_codec_model

/* File: spx_consts.vh */
// Constants for the framed serial port: register map, fields, resets, word lengths
`ifndef SPX_CONSTS_VH
`define SPX_CONSTS_VH

// Register byte offsets
`define SPX_A_TXBUF    4'h0
`define SPX_A_RXBUF    4'h4
`define SPX_A_CTRL     4'h8
`define SPX_A_STAT     4'hc

// Control field positions
`define SPX_C_FSREQ    0
`define SPX_C_TXINT    1
`define SPX_C_BYTE     2

// Control reset values
`define SPX_RST_FSREQ  1'b1
`define SPX_RST_TXINT  1'b0
`define SPX_RST_BYTE   1'b0

// Status field positions
`define SPX_S_TXPEND   0
`define SPX_S_TXBUSY   1
`define SPX_S_RXBUSY   2
`define SPX_S_TXRUN    3
`define SPX_S_RXRUN    4

// Index of the last bit of a word
`define SPX_LAST16     4'hf
`define SPX_LAST8      4'h7

// Bus answers
`define SPX_RESP_OK    2'b00
`define SPX_RESP_ERR   2'b10

`endif

/* File: spx_serial_port.v */
// Double-buffered framed serial port with an AXI4-Lite register slave
// Behaviour
// R1 - Burst transfers only with frame sync required
// R2 - Buffer write makes internal frame pulse
// R3 - Load shifter at frame high, start at fall
// R4 - After last bit: interrupt, output tri-stated
// R5 - Refill right after interrupt restarts framing
// R6 - Receive buffer loads at last bit, then interrupt
// R7 - Byte mode keeps previous byte above
// R8 - Format bit one selects eight-bit words
// R9 - Buffer write never aborts current word
// R10 - Early refill pulses frame on final bit
// R11 - Late refill tri-states output until rewritten
// R12 - Far end pulses frame during final bit
// R13 - Unframed mode ignores frame inputs, shifts continuously
// R14 - Frame output stays low while unframed
// R15 - Unframed without refill repeats last word
// R16 - Unframed receive loads every word, overrun allowed
// R17 - Unframed stops on clock halt or reframe
// R18 - Unframed internal start: one frame pulse only
// R19 - Unframed external start waits one pulse
// R20 - First unframed word is sent twice
// R21 - Unframed receive waits one pulse, then ignores
// R22 - Send on rising, sample on falling, MSB first
// R23 - Sixteen-bit words, byte mode uses low byte
// R24 - Internal framing drives frame pin as output
// R25 - Reset clears internal framing, tri-states, aborts
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "spx_consts.vh"
module spx_serial_port #(
    parameter AW = 4
) (
    input  wire          aclk,
    input  wire          aresetn,
    input  wire [AW-1:0] s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output wire          s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output wire          s_axi_wready,
    output wire [1:0]    s_axi_bresp,
    output wire          s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [AW-1:0] s_axi_araddr,
    input  wire          s_axi_arvalid,
    output wire          s_axi_arready,
    output wire [31:0]   s_axi_rdata,
    output wire [1:0]    s_axi_rresp,
    output wire          s_axi_rvalid,
    input  wire          s_axi_rready,
    input  wire          tx_bit_clock,
    input  wire          tx_frame_sync_i,
    output wire          tx_frame_sync_o,
    output wire          tx_frame_sync_oe,
    output wire          tx_serial_out,
    output wire          tx_serial_oe,
    input  wire          rx_bit_clock,
    input  wire          rx_frame_sync,
    input  wire          rx_serial_in,
    output wire          tx_done_irq,
    output wire          rx_done_irq
);
    // Transmit states
    localparam [1:0] TX_IDLE  = 2'b00;  // Nothing loaded
    localparam [1:0] TX_LOAD  = 2'b01;  // Shifter loaded, waiting frame end
    localparam [1:0] TX_SHIFT = 2'b10;  // Sending bits
    // Receive states
    localparam [0:0] RX_IDLE  = 1'b0;   // Waiting for a frame pulse
    localparam [0:0] RX_SHIFT = 1'b1;   // Sampling bits

    // Index of the last bit for the selected format
    function [3:0] spx_last;
        input byte_mode;
        begin
            spx_last = byte_mode ? `SPX_LAST8 : `SPX_LAST16;  // see R8, R23
        end
    endfunction

    // Word as it enters the shifter, MSB at bit 15
    function [15:0] spx_align;
        input        byte_mode;
        input [15:0] word;
        begin
            spx_align = byte_mode ? {word[7:0], 8'h00} : word;  // see R23
        end
    endfunction

    // Synchronised pins
    wire [4:0] pin_lvl;   // Levels after two flops
    wire [4:0] pin_rise;  // Rising edges
    wire [4:0] pin_fall;  // Falling edges

    spx_sync #(
        .W (5)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     ({rx_serial_in, rx_frame_sync, tx_frame_sync_i,
                   rx_bit_clock, tx_bit_clock}),
        .level   (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    wire tck_rise = pin_rise[0];  // Transmit clock rose
    wire tck_fall = pin_fall[0];  // Transmit clock fell
    wire rck_rise = pin_rise[1];  // Receive clock rose
    wire rck_fall = pin_fall[1];  // Receive clock fell
    wire tfs_in   = pin_lvl[2];   // External transmit frame
    wire rfs_in   = pin_lvl[3];   // Receive frame
    wire rdat_in  = pin_lvl[4];   // Receive data

    // Control bits
    reg         fsreq_r;   // Frame sync required
    reg         txint_r;   // Transmit framing internal
    reg         byte_r;    // Byte format select
    // Bus state
    reg         aw_hold_r; // Write address taken
    reg [AW-1:0] aw_addr_r; // Held write address
    reg         w_hold_r;  // Write data taken
    reg [31:0]  w_data_r;  // Held write data
    reg [3:0]   w_strb_r;  // Held byte enables
    reg         bvalid_r;  // Write answer pending
    reg [1:0]   bresp_r;   // Write answer code
    reg         rvalid_r;  // Read answer pending
    reg [31:0]  rdata_r;   // Read answer data
    reg [1:0]   rresp_r;   // Read answer code
    // Transmit state
    reg [15:0]  tx_buffer_r;  // Software word
    reg         tx_pend_r;    // Buffer holds an unsent word
    reg [15:0]  tx_shifter_r; // Bits still to go
    reg [15:0]  tx_last_r;    // Last word loaded
    reg [1:0]   tx_st_r;      // Transmit state
    reg [3:0]   tx_cnt_r;     // Bit being sent
    reg         tx_reload_r;  // Next word loaded during final bit
    reg         tx_run_r;     // Unframed stream running
    reg         tx_fs_r;      // Internal frame pulse
    reg         tx_dat_r;     // Data pin value
    reg         tx_oe_r;      // Data pin driven
    reg         tx_irq_r;     // Transmit done pulse
    // Receive state
    reg [15:0]  rx_shifter_r; // Bits gathered
    reg [15:0]  rx_buffer_r;  // Completed word
    reg         rx_st_r;      // Receive state
    reg [3:0]   rx_cnt_r;     // Bit being sampled
    reg         rx_run_r;     // Unframed stream running
    reg         rx_due_r;     // Interrupt waits for clock rise
    reg         rx_irq_r;     // Receive done pulse

    // Bus handshakes
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready  = !w_hold_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // Pins and events
    assign tx_frame_sync_o  = tx_fs_r;
    assign tx_frame_sync_oe = txint_r;  // see R24
    assign tx_serial_out    = tx_dat_r;
    assign tx_serial_oe     = tx_oe_r;
    assign tx_done_irq      = tx_irq_r;
    assign rx_done_irq      = rx_irq_r;

    // Write happens once both address and data are held
    wire        wr_go  = aw_hold_r && w_hold_r && !bvalid_r;
    wire        wr_tx  = wr_go && (aw_addr_r == `SPX_A_TXBUF);
    wire        wr_ctl = wr_go && (aw_addr_r == `SPX_A_CTRL);
    // Frame level the transmitter follows
    wire        tx_fs_in_gate = tfs_in;
    wire        tx_fs_eff = txint_r ? tx_fs_r : tx_fs_in_gate;
    wire [3:0]  tx_lastbit = spx_last(byte_r);
    wire [3:0]  rx_lastbit = spx_last(byte_r);
    // Word that follows in the unframed stream
    wire [15:0] tx_next_w = tx_pend_r ? tx_buffer_r : tx_last_r;  // see R15, R20
    wire [15:0] tx_next_al = spx_align(byte_r, tx_next_w);  // Next stream word, MSB at top
    // Software word merged with byte enables
    wire [15:0] tx_wr_w = {w_strb_r[1] ? w_data_r[15:8] : tx_buffer_r[15:8],
                           w_strb_r[0] ? w_data_r[7:0] : tx_buffer_r[7:0]};
    // Status word
    wire [31:0] stat_w = ({31'h0, tx_pend_r} << `SPX_S_TXPEND)
                       | ({31'h0, tx_st_r != TX_IDLE} << `SPX_S_TXBUSY)
                       | ({31'h0, rx_st_r} << `SPX_S_RXBUSY)
                       | ({31'h0, tx_run_r} << `SPX_S_TXRUN)
                       | ({31'h0, rx_run_r} << `SPX_S_RXRUN);
    wire [31:0] ctrl_w = ({31'h0, fsreq_r} << `SPX_C_FSREQ)
                       | ({31'h0, txint_r} << `SPX_C_TXINT)
                       | ({31'h0, byte_r} << `SPX_C_BYTE);

    // Write channel: hold address and data, perform, answer
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= {AW{1'b0}};
            w_hold_r  <= 1'b0;
            w_data_r  <= 32'h0;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `SPX_RESP_OK;
        end else begin
            // Take address
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            // Take data
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            // Both present: answer
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                if (aw_addr_r == `SPX_A_TXBUF || aw_addr_r == `SPX_A_CTRL) begin
                    bresp_r <= `SPX_RESP_OK;
                end else if (aw_addr_r == `SPX_A_RXBUF || aw_addr_r == `SPX_A_STAT) begin
                    bresp_r <= `SPX_RESP_OK;  // Read-only, write ignored
                end else begin
                    bresp_r <= `SPX_RESP_ERR;
                end
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Control register
    always @(posedge aclk) begin
        if (!aresetn) begin
            fsreq_r <= `SPX_RST_FSREQ;
            txint_r <= `SPX_RST_TXINT;  // see R25
            byte_r  <= `SPX_RST_BYTE;
        end else if (wr_ctl && w_strb_r[0]) begin
            fsreq_r <= w_data_r[`SPX_C_FSREQ];
            txint_r <= w_data_r[`SPX_C_TXINT];
            byte_r  <= w_data_r[`SPX_C_BYTE];  // see R8
        end
    end

    // Read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0;
            rresp_r  <= `SPX_RESP_OK;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r  <= `SPX_RESP_OK;
            if (s_axi_araddr == `SPX_A_TXBUF) begin
                rdata_r <= {16'h0, tx_buffer_r};
            end else if (s_axi_araddr == `SPX_A_RXBUF) begin
                rdata_r <= {16'h0, rx_buffer_r};
            end else if (s_axi_araddr == `SPX_A_CTRL) begin
                rdata_r <= ctrl_w;
            end else if (s_axi_araddr == `SPX_A_STAT) begin
                rdata_r <= stat_w;
            end else begin
                rdata_r <= 32'h0;
                rresp_r <= `SPX_RESP_ERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Transmitter, stepped by synchronised clock edges
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_buffer_r  <= 16'h0;
            tx_pend_r    <= 1'b0;
            tx_shifter_r <= 16'h0;
            tx_last_r    <= 16'h0;
            tx_st_r      <= TX_IDLE;  // see R25
            tx_cnt_r     <= 4'h0;
            tx_reload_r  <= 1'b0;
            tx_run_r     <= 1'b0;
            tx_fs_r      <= 1'b0;
            tx_dat_r     <= 1'b0;
            tx_oe_r      <= 1'b0;     // see R25
            tx_irq_r     <= 1'b0;
        end else begin
            tx_irq_r <= 1'b0;
            if (tck_rise) begin
                case (tx_st_r)
                    TX_IDLE: begin
                        // Pulse only in framed mode or before an unframed start
                        if (tx_pend_r && txint_r && !tx_run_r) begin
                            tx_fs_r <= 1'b1;  // see R1, R2, R5, R18
                        end
                    end
                    TX_LOAD: begin
                        // Frame ends: begin sending the MSB
                        if (txint_r || !tx_fs_eff) begin
                            tx_fs_r      <= 1'b0;  // see R3
                            tx_dat_r     <= tx_shifter_r[15];  // see R22
                            tx_shifter_r <= {tx_shifter_r[14:0], 1'b0};
                            tx_cnt_r     <= 4'h0;
                            tx_oe_r      <= 1'b1;
                            tx_st_r      <= TX_SHIFT;
                            tx_run_r     <= !fsreq_r;  // see R19
                        end
                    end
                    TX_SHIFT: begin
                        if (tx_cnt_r == tx_lastbit) begin
                            tx_irq_r <= 1'b1;  // see R4
                            tx_cnt_r <= 4'h0;
                            if (!fsreq_r) begin
                                // Stream on, refilled or repeated
                                tx_dat_r     <= tx_next_al[15];  // see R13
                                tx_shifter_r <= {tx_next_al[14:0], 1'b0};
                                tx_last_r    <= tx_next_w;  // see R15, R20
                                tx_pend_r    <= 1'b0;
                                tx_fs_r      <= 1'b0;  // see R14
                                tx_run_r     <= 1'b1;
                            end else if (tx_reload_r) begin
                                // Next word already loaded
                                tx_fs_r      <= 1'b0;  // see R10
                                tx_dat_r     <= tx_shifter_r[15];
                                tx_shifter_r <= {tx_shifter_r[14:0], 1'b0};
                                tx_reload_r  <= 1'b0;
                                tx_run_r     <= 1'b0;
                            end else begin
                                // No refill: release the pin
                                tx_oe_r  <= 1'b0;  // see R4, R11, R17
                                tx_st_r  <= TX_IDLE;
                                tx_run_r <= 1'b0;
                            end
                        end else begin
                            tx_dat_r     <= tx_shifter_r[15];  // see R22
                            tx_shifter_r <= {tx_shifter_r[14:0], 1'b0};
                            tx_cnt_r     <= tx_cnt_r + 4'h1;
                            // Final bit starting with a word waiting
                            if (tx_cnt_r + 4'h1 == tx_lastbit && tx_pend_r
                                && txint_r && fsreq_r) begin
                                tx_fs_r <= 1'b1;  // see R10
                            end
                        end
                    end
                    default: begin
                        tx_st_r <= TX_IDLE;
                    end
                endcase
            end else if (tck_fall && tx_fs_eff && tx_pend_r) begin
                // Frame high, clock low: copy buffer into shifter
                if (tx_st_r == TX_IDLE && !tx_run_r) begin
                    tx_shifter_r <= spx_align(byte_r, tx_buffer_r);  // see R3, R19
                    tx_last_r    <= tx_buffer_r;
                    tx_pend_r    <= 1'b0;
                    tx_st_r      <= TX_LOAD;
                end else if (tx_st_r == TX_SHIFT && tx_cnt_r == tx_lastbit
                             && fsreq_r && !tx_reload_r) begin
                    tx_shifter_r <= spx_align(byte_r, tx_buffer_r);  // see R10
                    tx_last_r    <= tx_buffer_r;
                    tx_pend_r    <= 1'b0;
                    tx_reload_r  <= 1'b1;
                end
            end
            // Software write lands last so it is never lost
            if (wr_tx) begin
                tx_buffer_r <= tx_wr_w;  // see R9
                tx_pend_r   <= 1'b1;
            end
        end
    end

    // Receiver, stepped by synchronised clock edges
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_shifter_r <= 16'h0;
            rx_buffer_r  <= 16'h0;
            rx_st_r      <= RX_IDLE;  // see R25
            rx_cnt_r     <= 4'h0;
            rx_run_r     <= 1'b0;
            rx_due_r     <= 1'b0;
            rx_irq_r     <= 1'b0;
        end else begin
            rx_irq_r <= 1'b0;
            if (rck_fall) begin
                case (rx_st_r)
                    RX_IDLE: begin
                        // One frame pulse opens a word or a stream
                        if (rfs_in) begin
                            rx_st_r  <= RX_SHIFT;  // see R21
                            rx_cnt_r <= 4'h0;
                        end
                    end
                    RX_SHIFT: begin
                        rx_shifter_r <= {rx_shifter_r[14:0], rdat_in};  // see R22
                        if (rx_cnt_r == rx_lastbit) begin
                            // Clock low after the last bit: post the word
                            if (byte_r) begin
                                rx_buffer_r <= {rx_buffer_r[7:0],
                                                rx_shifter_r[6:0], rdat_in};  // see R7
                            end else begin
                                rx_buffer_r <= {rx_shifter_r[14:0], rdat_in};  // see R6
                            end
                            rx_due_r <= 1'b1;  // see R16
                            rx_cnt_r <= 4'h0;
                            rx_run_r <= !fsreq_r;
                            // Framed: continue only on a pulse in the final bit
                            if (fsreq_r && !rfs_in) begin
                                rx_st_r <= RX_IDLE;  // see R12, R17
                            end
                        end else begin
                            rx_cnt_r <= rx_cnt_r + 4'h1;  // see R13
                        end
                    end
                    default: begin
                        rx_st_r <= RX_IDLE;
                    end
                endcase
            end
            // Interrupt on the next rising receive clock
            if (rck_rise && rx_due_r) begin
                rx_irq_r <= 1'b1;  // see R6
                rx_due_r <= 1'b0;
            end
        end
    end
endmodule // spx_serial_port

/* File: spx_serial_port_chk.sv */
// Checker for the serial port pins and register handshakes
`timescale 1ns/10ps
module spx_serial_port_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic tx_bit_clock,
    input wire logic rx_bit_clock,
    input wire logic tx_frame_sync_o,
    input wire logic tx_frame_sync_oe,
    input wire logic tx_serial_out,
    input wire logic tx_serial_oe,
    input wire logic tx_done_irq,
    input wire logic rx_done_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Address and data taken at one edge
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Bit clock held low long enough for the synchroniser to settle
    sequence s_tx_low;
        (tx_serial_oe && !tx_bit_clock) [*5];
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
        !tx_serial_oe && !tx_frame_sync_oe && !tx_done_irq) else $error("reset not quiet");
    a_tx_irq_rise: assert property (tx_done_irq |-> tx_bit_clock)
        else $error("tx irq off a clock rise");
    a_rx_irq_rise: assert property (rx_done_irq |-> rx_bit_clock)
        else $error("rx irq off a clock rise");
    a_rx_irq_pulse: assert property (rx_done_irq |=> !rx_done_irq)
        else $error("rx irq longer than one cycle");
    a_data_hold: assert property (s_tx_low |-> $stable(tx_serial_out))
        else $error("tx data moved while clock low");
    a_frame_pin: assert property (tx_frame_sync_o |-> tx_frame_sync_oe)
        else $error("frame pulse on undriven pin");
    a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule // spx_serial_port_chk
bind spx_serial_port spx_serial_port_chk chk_i (.*);

/* File: spx_serial_port_tb.sv */
// Self-checking bench: register tasks, byte and word transfers
`timescale 1ns/10ps
`include "spx_consts.vh"
module spx_serial_port_tb;
    logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, rx_go = 1'b0, tx_frame_sync_i = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_bit_clock, tx_frame_sync_o, tx_frame_sync_oe, tx_serial_out, tx_serial_oe;
    logic rx_bit_clock, rx_frame_sync, rx_serial_in, tx_done_irq, rx_done_irq;
    logic [15:0] rx_word = 16'h0, tx_cap;
    logic [4:0] rx_bits = 5'h8;
    int n_errors = 0, n_tests = 0, k;
    spx_serial_port DUT (.*);
    spx_codec_model far_end (.*);
    always #5 aclk = ~aclk;
    task automatic summarize;
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Handshakes decided at the low phase, released after the edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        int i;
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready; tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge aclk);
            if (ta === 1'b1) s_axi_awvalid <= 1'b0;
            if (tw === 1'b1) s_axi_wvalid <= 1'b0;
            if (tb === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        if (i == 50) begin n_errors++; summarize(); end
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        logic ta, tr;
        int i;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge aclk);
            ta = s_axi_arvalid & s_axi_arready; tr = s_axi_rvalid; d = s_axi_rdata;
            @(posedge aclk);
            if (ta === 1'b1) s_axi_arvalid <= 1'b0;
            if (tr === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        if (i == 50) begin n_errors++; summarize(); end
        @(posedge aclk);
    endtask
    // Bounded wait for a completion pulse
    task automatic wt(input logic tx);
        int i;
        for (i = 0; i < 1000; i++) begin
            @(negedge aclk);
            if ((tx ? tx_done_irq : rx_done_irq) === 1'b1) break;
        end
        if (i == 1000) begin n_errors++; summarize(); end
        @(posedge aclk);
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("serial oe", tx_serial_oe, 1'b0);
        rd(`SPX_A_CTRL, q);
        chk("ctrl reset", q, 32'h1);
        run <= 1'b1;
        wr(`SPX_A_CTRL, 32'h7);
        wr(`SPX_A_TXBUF, 32'h12a5);
        wt(1'b1);
        chk("tx byte", tx_cap[7:0], 8'ha5);
        chk("frame oe", tx_frame_sync_oe, 1'b1);
        repeat (5) @(posedge aclk);
        chk("oe idle", tx_serial_oe, 1'b0);
        rx_word <= 16'h003c; rx_go <= ~rx_go; wt(1'b0);
        rx_word <= 16'h00c3; rx_go <= ~rx_go; wt(1'b0);
        rd(`SPX_A_RXBUF, q);
        chk("rx pair", q, 32'h3cc3);
        wr(`SPX_A_CTRL, 32'h3);
        rx_bits <= 5'h10; rx_word <= 16'hbeef; rx_go <= ~rx_go; wt(1'b0);
        rd(`SPX_A_RXBUF, q);
        chk("rx word", q, 32'hbeef);
        wr(`SPX_A_TXBUF, 32'h1234);
        for (k = 0; k < 100; k++) begin
            rd(`SPX_A_STAT, q);
            if (q[1:0] === 2'b10) break;
        end
        chk("tx loaded", q[1:0], 2'b10);
        wr(`SPX_A_TXBUF, 32'habcd);
        wt(1'b1);
        chk("tx first", tx_cap, 16'h1234);
        wt(1'b1);
        chk("tx next", tx_cap, 16'habcd);
        wr(`SPX_A_CTRL, 32'h2);
        wr(`SPX_A_TXBUF, 32'h5a3c);
        wt(1'b1);
        chk("tx stream", tx_cap, 16'h5a3c);
        wt(1'b1);
        chk("tx repeat", tx_cap, 16'h5a3c);
        run <= 1'b0;
        summarize();
    end
endmodule // spx_serial_port_tb

/* File: spx_sync.v */
// Two-flop synchroniser with edge detection for the serial port pins
`timescale 1ns/10ps
module spx_sync #(
    parameter W = 5
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] din,
    output wire [W-1:0] level,
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);
    reg [W-1:0] meta_r;  // First stage, read only by the second
    reg [W-1:0] sync_r;  // Second stage, safe level
    reg [W-1:0] prev_r;  // Delayed copy for edge detection

    // Synchronise and delay
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
            prev_r <= {W{1'b0}};
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;
    assign fall  = ~sync_r & prev_r;
endmodule // spx_sync
